// file: uart_buffer_irq_dma_control.sv
/*
 * Serial transceiver with single holding and receive buffers, combined
 * interrupt with cause register, DMA requests, APB register file.
 * Assumes APB master on core_clk, rxd from an asynchronous line.
 */
`timescale 1ns/1ps
module uart_buffer_irq_dma_control
	import uart_ctrl_pkg::*;
#(
	parameter int OVERSAMPLE = 16
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             irq,
	output logic             txDmaReq,
	output logic             rxDmaReq
);

	localparam int SUB_W = $clog2(OVERSAMPLE);
	localparam logic [SUB_W-1:0] LAST_SUB = SUB_W'(OVERSAMPLE - 1);
	localparam logic [SUB_W-1:0] MID_SUB  = SUB_W'(OVERSAMPLE / 2 - 1);

	if (OVERSAMPLE < 4 || (OVERSAMPLE & (OVERSAMPLE - 1)) != 0) begin : g_chk
		$error("OVERSAMPLE must be a power of two of at least 4");
	end

	function automatic logic isAddr(input logic [31:0] a,
		input logic [31:0] off);
		return a == off;
	endfunction

	// parity of the used data bits; odd parity is the inverse
	function automatic logic parityOf(input logic [7:0] d,
		input logic [2:0] lastBit, input logic even);
		logic p;
		p = ~even;
		for (int i = 0; i < 8; i++) begin
			if (3'(i) <= lastBit) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction

	// ==========================================================
	// register state
	logic [IRQ_ENABLE_W-1:0] ienQ;
	logic [15:0]             lcrQ, mcrQ, scrQ, fbrQ, divQ;
	logic                    disableQ;
	logic [7:0]              thrQ, rbrQ;
	line_flags_type          flagsQ, flagsD;
	logic                    thriQ, thriD;
	logic                    setupRd, accessQ, wrAcc, rdAcc, mapped;
	logic [31:0]             rdMux;
	logic                    dmaMode, lineIrq, rxIrq, txIrq, anyPend;
	logic [1:0]              cause;
	logic [2:0]              lastBit;

	assign setupRd = psel & ~penable;
	assign accessQ = psel & penable & pready;
	assign wrAcc   = accessQ & pwrite;
	assign rdAcc   = accessQ & ~pwrite;
	assign lastBit = lcrQ[WORD_LEN_LSB +: 3] & 3'h3 | MIN_WORD_BITS_M1;
	assign dmaMode = ienQ[TX_DMA_REQ_EN_BIT] | ienQ[RX_DMA_REQ_EN_BIT];

	// ==========================================================
	// interrupt sources and priority
	// sources of the request
	always_comb begin
		lineIrq = ienQ[RX_LINE_STATUS_EN_BIT] & (flagsQ.overrun
			| flagsQ.parityErr | flagsQ.frameErr
			| (flagsQ.breakSeen & ~dmaMode));
		rxIrq   = ienQ[RX_FULL_IRQ_EN_BIT] & flagsQ.ready;
		txIrq   = ienQ[TX_EMPTY_IRQ_EN_BIT] & thriQ;
		anyPend = lineIrq | rxIrq | txIrq;
		if (lineIrq) begin
			cause = CAUSE_LINE;
		end else if (rxIrq) begin
			cause = CAUSE_RX_FULL;
		end else if (txIrq) begin
			cause = CAUSE_TX_EMPTY;
		end else begin
			cause = CAUSE_MODEM;
		end
	end

	// ==========================================================
	// APB read mux and decode
	always_comb begin
		rdMux  = '0;
		mapped = 1'b1;
		case (paddr)
			RX_BUFFER_ADDR:       rdMux = {24'h0, rbrQ};
			IRQ_ENABLE_ADDR:      rdMux = {26'h0, ienQ};
			IRQ_IDENT_ADDR:       rdMux = {29'h0, cause, ~anyPend};
			LINE_CONTROL_ADDR:    rdMux = {16'h0, lcrQ};
			MODEM_CONTROL_ADDR:   rdMux = {16'h0, mcrQ};
			LINE_STATUS_ADDR:     rdMux = {25'h0, flagsQ};
			MODEM_STATUS_ADDR:    rdMux = '0;
			SCRATCH_PAD_ADDR:     rdMux = {16'h0, scrQ};
			FRACTIONAL_BAUD_ADDR: rdMux = {16'h0, fbrQ};
			BAUD_DIVIDER_ADDR:    rdMux = {16'h0, divQ};
			PERIPH_CTRL_ADDR:     rdMux = {31'h0, disableQ};
			default:              mapped = 1'b0;
		endcase
	end

	// zero-wait slave: answer prepared in the setup cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setupRd;
			pslverr <= setupRd & ~mapped;
			prdata  <= (setupRd & ~pwrite) ? rdMux : '0;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ienQ     <= '0;
			lcrQ     <= REG_RESET_ZERO;
			mcrQ     <= REG_RESET_ZERO;
			scrQ     <= REG_RESET_ZERO;
			fbrQ     <= REG_RESET_ZERO;
			divQ     <= BAUD_DIV_RESET;
			disableQ <= 1'b0;
		end else if (wrAcc) begin
			if (isAddr(paddr, IRQ_ENABLE_ADDR))
				ienQ <= pwdata[IRQ_ENABLE_W-1:0];
			if (isAddr(paddr, LINE_CONTROL_ADDR))
				lcrQ <= pwdata[15:0];
			if (isAddr(paddr, MODEM_CONTROL_ADDR))
				mcrQ <= pwdata[15:0];
			if (isAddr(paddr, SCRATCH_PAD_ADDR))
				scrQ <= pwdata[15:0];
			if (isAddr(paddr, FRACTIONAL_BAUD_ADDR))
				fbrQ <= pwdata[15:0];
			if (isAddr(paddr, BAUD_DIVIDER_ADDR))
				divQ <= pwdata[15:0];
			if (isAddr(paddr, PERIPH_CTRL_ADDR))
				disableQ <= pwdata[DISABLE_BIT];
		end
	end

	// ==========================================================
	// baud tick; freezing it models the stopped peripheral clock
	logic [16:0] baudCntQ;
	logic        tickQ;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			baudCntQ <= '0;
			tickQ    <= 1'b0;
		end else if (disableQ) begin
			tickQ <= 1'b0;
		end else if (baudCntQ + 17'h1 >= {divQ, 1'b0}) begin
			baudCntQ <= '0;
			tickQ    <= 1'b1;
		end else begin
			baudCntQ <= baudCntQ + 17'h1;
			tickQ    <= 1'b0;
		end
	end

	// ==========================================================
	// transmitter: holding register feeds shift register
	serial_state_type txState;
	logic [7:0]       txShift;
	logic [SUB_W-1:0] txSub;
	logic [2:0]       txBit;
	logic             txPar, txLine, thrMove, thrWrite;

	assign thrWrite = wrAcc & isAddr(paddr, TX_HOLDING_ADDR);
	assign thrMove  = ~disableQ & (txState == ST_IDLE) & ~flagsQ.txEmpty;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			thrQ <= '0;
		end else if (thrWrite) begin
			thrQ <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			txState <= ST_IDLE;
			txShift <= '0;
			txSub   <= '0;
			txBit   <= '0;
			txPar   <= 1'b0;
			txLine  <= 1'b1;
		end else if (!disableQ) begin
			case (txState)
				ST_IDLE: begin
					if (thrMove) begin
						txShift <= thrQ;
						txPar   <= parityOf(thrQ, lastBit,
							lcrQ[PARITY_EVN_BIT]);
						txSub   <= '0;
						txBit   <= '0;
						txLine  <= 1'b0;
						txState <= ST_START;
					end
				end
				default: begin
					if (tickQ) begin
						txSub <= txSub + 1'b1;
						if (txSub == LAST_SUB) begin
							case (txState)
								ST_START: begin
									txLine  <= txShift[0];
									txState <= ST_DATA;
								end
								ST_DATA: begin
									if (txBit == lastBit) begin
										if (lcrQ[PARITY_EN_BIT]) begin
											txLine  <= txPar;
											txState <= ST_PARITY;
										end else begin
											txLine  <= 1'b1;
											txState <= ST_STOP;
										end
									end else begin
										txShift <= txShift >> 1;
										txLine  <= txShift[1];
										txBit   <= txBit + 1'b1;
									end
								end
								ST_PARITY: begin
									txLine  <= 1'b1;
									txState <= ST_STOP;
								end
								default: txState <= ST_IDLE;
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			txd <= 1'b1;
		end else begin
			txd <= txLine & ~lcrQ[BREAK_SET_BIT];
		end
	end

	// ==========================================================
	// receiver
	logic             rxMeta, rxSync;
	serial_state_type rxState;
	logic [7:0]       rxShift;
	logic [SUB_W-1:0] rxSub;
	logic [2:0]       rxBit;
	logic             rxParBit, rxDoneQ, rxStopQ;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
		end else begin
			rxMeta <= rxd;
			rxSync <= rxMeta;
		end
	end

	// partial word stays in rxShift when frozen
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxState  <= ST_IDLE;
			rxShift  <= '0;
			rxSub    <= '0;
			rxBit    <= '0;
			rxParBit <= 1'b0;
			rxDoneQ  <= 1'b0;
			rxStopQ  <= 1'b1;
		end else begin
			rxDoneQ <= 1'b0;
			if (!disableQ && tickQ) begin
				rxSub <= rxSub + 1'b1;
				case (rxState)
					ST_IDLE: begin
						rxSub <= '0;
						if (!rxSync) rxState <= ST_START;
					end
					ST_START: begin
						if (rxSub == MID_SUB) begin
							rxSub   <= '0;
							rxBit   <= '0;
							rxState <= rxSync ? ST_IDLE : ST_DATA;
						end
					end
					ST_DATA: begin
						if (rxSub == LAST_SUB) begin
							rxShift <= {rxSync, rxShift[7:1]};
							rxBit   <= rxBit + 1'b1;
							if (rxBit == lastBit)
								rxState <= lcrQ[PARITY_EN_BIT] ?
									ST_PARITY : ST_STOP;
						end
					end
					ST_PARITY: begin
						if (rxSub == LAST_SUB) begin
							rxParBit <= rxSync;
							rxState  <= ST_STOP;
						end
					end
					default: begin
						if (rxSub == LAST_SUB) begin
							rxStopQ <= rxSync;
							rxDoneQ <= 1'b1;
							rxState <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// status flags, receive buffer, tx-empty interrupt latch
	logic [7:0] rxWord;
	logic       rdRbr, rdLsr, rdIir, ienTxRise;

	assign rxWord    = rxShift >> (MAX_BIT_INDEX - lastBit);
	assign rdRbr     = rdAcc & isAddr(paddr, RX_BUFFER_ADDR);
	assign rdLsr     = rdAcc & isAddr(paddr, LINE_STATUS_ADDR);
	assign rdIir     = rdAcc & isAddr(paddr, IRQ_IDENT_ADDR);
	assign ienTxRise = wrAcc & isAddr(paddr, IRQ_ENABLE_ADDR)
		& pwdata[TX_EMPTY_IRQ_EN_BIT] & ~ienQ[TX_EMPTY_IRQ_EN_BIT];

	// hardware set beats software clear in every flag but txEmpty, where thrWrite wins
	always_comb begin
		flagsD = flagsQ;
		if (rdLsr) begin
			flagsD.overrun   = 1'b0;
			flagsD.parityErr = 1'b0;
			flagsD.frameErr  = 1'b0;
			flagsD.breakSeen = 1'b0;
		end
		if (rdRbr) flagsD.ready = 1'b0;
		if (rxDoneQ) begin
			flagsD.ready = 1'b1;
			if (flagsQ.ready) flagsD.overrun = 1'b1;
			if (parityOf(rxWord, lastBit, lcrQ[PARITY_EVN_BIT])
				!= rxParBit && lcrQ[PARITY_EN_BIT])
				flagsD.parityErr = 1'b1;
			if (!rxStopQ) flagsD.frameErr = 1'b1;
			if (!rxStopQ && rxWord == 8'h00) flagsD.breakSeen = 1'b1;
		end
		// overwrite of a full holding register is not checked
		if (thrMove) flagsD.txEmpty = 1'b1;
		if (thrWrite) flagsD.txEmpty = 1'b0;
		flagsD.txIdle = flagsD.txEmpty & (txState == ST_IDLE);
		thriD = thriQ;
		if (thrWrite || (rdIir && anyPend && cause == CAUSE_TX_EMPTY))
			thriD = 1'b0;
		// enabling while empty raises it at once
		if (thrMove || (ienTxRise && flagsQ.txEmpty)) thriD = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			flagsQ <= LINE_FLAGS_RESET;
			thriQ  <= 1'b0;
			rbrQ   <= '0;
		end else begin
			flagsQ <= flagsD;
			thriQ  <= thriD;
			// buffer only changes on a new word
			if (rxDoneQ) rbrQ <= rxWord;
		end
	end

	// ==========================================================
	// interrupt and DMA outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq      <= 1'b0;
			txDmaReq <= 1'b0;
			rxDmaReq <= 1'b0;
		end else begin
			irq      <= anyPend;
			// gated DMA requests from next-state flags
			txDmaReq <= ienQ[TX_DMA_REQ_EN_BIT] & flagsD.txEmpty;
			rxDmaReq <= ienQ[RX_DMA_REQ_EN_BIT] & flagsD.ready;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_thr_overwrite: assert property (
		thrWrite |=> thrQ == $past(pwdata[7:0]) && !flagsQ.txEmpty)
		else $error("holding register not overwritten");
	chk_rbr_reread: assert property (
		(setupRd && !pwrite && isAddr(paddr, RX_BUFFER_ADDR))
		|=> prdata[7:0] == $past(rbrQ))
		else $error("receive buffer read returned wrong word");
	chk_no_misuse_flag: assert property (
		(thrWrite && !flagsQ.txEmpty && !rxDoneQ && !rdLsr)
		|=> $stable(flagsQ.overrun) && $stable(flagsQ.frameErr))
		else $error("misuse changed status flags");
	chk_disable_freeze: assert property (
		disableQ && $past(disableQ) |-> $stable(txState)
		&& $stable(rxShift) && $stable(txShift) && !tickQ)
		else $error("shifting continued while disabled");
	chk_irq_combined: assert property (
		(rxIrq || txIrq) |=> irq)
		else $error("interrupt output not raised");
	chk_break_dma: assert property (
		(dmaMode && !flagsQ.overrun && !flagsQ.parityErr
		&& !flagsQ.frameErr) |-> !lineIrq)
		else $error("break interrupt raised in DMA mode");
	chk_tx_enable_now: assert property (
		(ienTxRise && flagsQ.txEmpty && !thrWrite) |-> ##2 irq)
		else $error("tx empty interrupt not immediate");
	chk_dma_gate: assert property (
		(txDmaReq |-> $past(ienQ[TX_DMA_REQ_EN_BIT]))
		and (rxDmaReq |-> $past(ienQ[RX_DMA_REQ_EN_BIT])))
		else $error("DMA request while disabled");
	chk_cause_priority: assert property (
		lineIrq |-> cause == CAUSE_LINE)
		else $error("line status not given priority");
	chk_apb_ready: assert property (
		setupRd |=> pready ##1 !pready)
		else $error("APB answer not one cycle after setup");

	cov_rx_word: cover property (rxDoneQ ##1 flagsQ.ready);
	cov_tx_word: cover property (thrMove ##[1:1000] txState == ST_STOP);
	cov_overrun: cover property (rxDoneQ && flagsQ.ready);
	cov_dma_tx: cover property (txDmaReq ##1 thrWrite);

endmodule // uart_buffer_irq_dma_control

// file: uart_buffer_irq_dma_control_tb_top.sv
/*
 * Self-checking bench for the serial buffer, interrupt and DMA block.
 * Assumes the design package, the remote model and zero-wait APB.
 */
`timescale 1ns/1ps
module uart_buffer_irq_dma_control_tb_top
	import uart_ctrl_pkg::*;
;
	logic        core_clk, rst, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, rnd, rdat;
	logic        pready, pslverr, rxd, txd, irq, txDmaReq, rxDmaReq, rerr;
	logic        hold;
	int          n_fail, cmp_count, cyc, c0;
	logic [31:0] ra [11] = '{RX_BUFFER_ADDR, IRQ_ENABLE_ADDR, IRQ_IDENT_ADDR,
		LINE_CONTROL_ADDR, MODEM_CONTROL_ADDR, LINE_STATUS_ADDR,
		MODEM_STATUS_ADDR, SCRATCH_PAD_ADDR, FRACTIONAL_BAUD_ADDR,
		BAUD_DIVIDER_ADDR, PERIPH_CTRL_ADDR};
	logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000,
		16'h0000, 16'h0060, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000};

	uart_buffer_irq_dma_control uut (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq),
		.txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq));
	uart_remote_model remote (.core_clk(core_clk), .lineIn(txd),
		.lineOut(rxd));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [31:0] ident_of(input logic ln, rf, te);
		if (ln)
			return 32'h00000006;
		if (rf)
			return 32'h00000004;
		if (te)
			return 32'h00000002;
		return 32'h00000001;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [31:0] a, d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			n_fail++;
	endtask

	task automatic rdchk(input logic [31:0] a, exp, input string what);
		apb(1'b0, a, 32'h00000000);
		chk(what, exp, rdat);
	endtask

	task automatic wait_irq(input logic v);
		for (int n = 0; n < 1000 && irq !== v; n++)
			@(posedge core_clk);
		chk("irq", {31'h0, v}, {31'h0, irq});
	endtask

	task automatic wait_rx(input int c);
		for (int n = 0; n < 2000 && remote.rxCount <= c; n++)
			@(posedge core_clk);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		rnd = 32'h7D8C5B82;
		{n_fail, cmp_count, cyc} = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 11; i++)
			rdchk(ra[i], {16'h0000, rv[i]}, "reset value");
		apb(1'b0, 32'h40005020, 32'h00000000);
		chk("unmapped error", 32'h00000001, {31'h0, rerr});
		apb(1'b1, IRQ_IDENT_ADDR, 32'h000000FF);
		rdchk(IRQ_IDENT_ADDR, 32'h00000001, "ident ro");
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			apb(1'b1, IRQ_ENABLE_ADDR, rnd);
			rdchk(IRQ_ENABLE_ADDR, {26'h0, rnd[5:0]}, "enable");
		end
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000000);
		apb(1'b1, LINE_CONTROL_ADDR, 32'h00000003);
		// second write lands in holding, third replaces it
		c0 = remote.rxCount;
		rnd = lfsr(rnd);
		apb(1'b1, TX_HOLDING_ADDR, {24'h0, rnd[7:0]});
		apb(1'b1, TX_HOLDING_ADDR, {24'h0, rnd[15:8]});
		apb(1'b1, TX_HOLDING_ADDR, {24'h0, rnd[23:16]});
		wait_rx(c0);
		chk("first sent", rnd[7:0], remote.rxWord);
		wait_rx(c0 + 1);
		chk("last sent", rnd[23:16], remote.rxWord);
		repeat (40) @(posedge core_clk);
		rdchk(LINE_STATUS_ADDR, 32'h00000060, "no misuse flag");
		repeat (400) @(posedge core_clk);
		chk("words sent", c0 + 2, remote.rxCount);
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000002);
		wait_irq(1'b1);
		// software reads ident to learn the cause
		rdchk(IRQ_IDENT_ADDR, ident_of(0, 0, 1), "tx empty");
		wait_irq(1'b0);
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000001);
		rnd = lfsr(rnd);
		remote.send_word(rnd[7:0], 1'b1);
		wait_irq(1'b1);
		rdchk(IRQ_IDENT_ADDR, ident_of(0, 1, 0), "rx full");
		// buffered word read before the next arrives
		rdchk(RX_BUFFER_ADDR, {24'h0, rnd[7:0]}, "rx word");
		rdchk(RX_BUFFER_ADDR, {24'h0, rnd[7:0]}, "re-read");
		rdchk(LINE_STATUS_ADDR, 32'h00000060, "no reread flag");
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000000);
		remote.send_word(rnd[15:8], 1'b1);
		repeat (4) @(posedge core_clk);
		chk("masked irq", 32'h0, {31'h0, irq});
		chk("rx dma off", 32'h0, {31'h0, rxDmaReq});
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000020);
		repeat (2) @(posedge core_clk);
		chk("rx dma on", 32'h1, {31'h0, rxDmaReq});
		rdchk(RX_BUFFER_ADDR, {24'h0, rnd[15:8]}, "dma rx word");
		repeat (2) @(posedge core_clk);
		chk("rx dma served", 32'h0, {31'h0, rxDmaReq});
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000010);
		repeat (2) @(posedge core_clk);
		chk("tx dma on", 32'h1, {31'h0, txDmaReq});
		c0 = remote.rxCount;
		apb(1'b1, TX_HOLDING_ADDR, {24'h0, rnd[23:16]});
		apb(1'b1, TX_HOLDING_ADDR, {24'h0, rnd[31:24]});
		repeat (3) @(posedge core_clk);
		chk("tx dma full", 32'h0, {31'h0, txDmaReq});
		wait_rx(c0 + 1);
		chk("dma tx word", rnd[31:24], remote.rxWord);
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000000);
		repeat (2) @(posedge core_clk);
		chk("tx dma off", 32'h0, {31'h0, txDmaReq});
		// overrun ranks above rx full
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000005);
		remote.send_word(rnd[7:0], 1'b1);
		remote.send_word(rnd[15:8], 1'b1);
		rdchk(IRQ_IDENT_ADDR, ident_of(1, 1, 0), "line first");
		rdchk(LINE_STATUS_ADDR, 32'h00000063, "overrun");
		rdchk(IRQ_IDENT_ADDR, ident_of(0, 1, 0), "rx next");
		apb(1'b0, RX_BUFFER_ADDR, 32'h00000000);
		rdchk(IRQ_IDENT_ADDR, ident_of(0, 0, 0), "none");
		remote.send_word(8'h00, 1'b0);
		wait_irq(1'b1);
		rdchk(IRQ_IDENT_ADDR, ident_of(1, 1, 0), "break");
		apb(1'b0, LINE_STATUS_ADDR, 32'h00000000);
		chk("break flags", 32'h18, rdat & 32'h18);
		apb(1'b0, RX_BUFFER_ADDR, 32'h00000000);
		// disabled mid-word on purpose, breaking the idle-line habit
		apb(1'b1, IRQ_ENABLE_ADDR, 32'h00000000);
		apb(1'b1, TX_HOLDING_ADDR, 32'h000000C3);
		for (int n = 0; n < 100 && txd !== 1'b0; n++)
			@(posedge core_clk);
		repeat (40) @(posedge core_clk);
		apb(1'b1, PERIPH_CTRL_ADDR, 32'h00000001);
		hold = txd;
		for (int i = 0; i < 10; i++) begin
			repeat (20) @(posedge core_clk);
			chk("txd frozen", {31'h0, hold}, {31'h0, txd});
		end
		rdchk(LINE_STATUS_ADDR, 32'h00000020, "partial word");
		apb(1'b1, PERIPH_CTRL_ADDR, 32'h00000000);
		repeat (400) @(posedge core_clk);
		// line idle again: park the transceiver as before power-down
		apb(1'b1, PERIPH_CTRL_ADDR, 32'h00000001);
		rdchk(PERIPH_CTRL_ADDR, 32'h00000001, "parked");
		report_and_stop();
	end
endmodule // uart_buffer_irq_dma_control_tb_top

// file: uart_ctrl_pkg.sv
/*
 * Constants and types for the serial transceiver buffer, interrupt and
 * DMA control block: register map, field positions, reset values,
 * interrupt cause codes, line state encoding.
 * Assumes a 32-bit APB with byte addresses.
 */
package uart_ctrl_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [31:0] TX_HOLDING_ADDR      = 32'h4000_5000;
	localparam logic [31:0] RX_BUFFER_ADDR       = 32'h4000_5000;
	localparam logic [31:0] IRQ_ENABLE_ADDR      = 32'h4000_5004;
	localparam logic [31:0] IRQ_IDENT_ADDR       = 32'h4000_5008;
	localparam logic [31:0] LINE_CONTROL_ADDR    = 32'h4000_500C;
	localparam logic [31:0] MODEM_CONTROL_ADDR   = 32'h4000_5010;
	localparam logic [31:0] LINE_STATUS_ADDR     = 32'h4000_5014;
	localparam logic [31:0] MODEM_STATUS_ADDR    = 32'h4000_5018;
	localparam logic [31:0] SCRATCH_PAD_ADDR     = 32'h4000_501C;
	localparam logic [31:0] FRACTIONAL_BAUD_ADDR = 32'h4000_5024;
	localparam logic [31:0] BAUD_DIVIDER_ADDR    = 32'h4000_5028;
	localparam logic [31:0] PERIPH_CTRL_ADDR     = 32'h4000_5030;

	// ==========================================================
	// reset values
	localparam logic [15:0] REG_RESET_ZERO    = 16'h0000;
	localparam logic [15:0] BAUD_DIV_RESET    = 16'h0001;

	// ==========================================================
	// irq_enable_reg fields
	localparam int RX_FULL_IRQ_EN_BIT     = 0;
	localparam int TX_EMPTY_IRQ_EN_BIT    = 1;
	localparam int RX_LINE_STATUS_EN_BIT  = 2;
	localparam int TX_DMA_REQ_EN_BIT      = 4;
	localparam int RX_DMA_REQ_EN_BIT      = 5;
	localparam int IRQ_ENABLE_W           = 6;

	// ==========================================================
	// line_control_reg fields, periph_ctrl field
	localparam int WORD_LEN_LSB   = 0;
	localparam int PARITY_EN_BIT  = 3;
	localparam int PARITY_EVN_BIT = 4;
	localparam int BREAK_SET_BIT  = 6;
	localparam int DISABLE_BIT    = 0;

	// ==========================================================
	// interrupt cause codes (irq_cause_code)
	localparam logic [1:0] CAUSE_MODEM    = 2'h0;
	localparam logic [1:0] CAUSE_TX_EMPTY = 2'h1;
	localparam logic [1:0] CAUSE_RX_FULL  = 2'h2;
	localparam logic [1:0] CAUSE_LINE     = 2'h3;

	// ==========================================================
	// serial timing
	localparam logic [2:0] MIN_WORD_BITS_M1 = 3'h4;
	localparam logic [2:0] MAX_BIT_INDEX    = 3'h7;

	typedef enum {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_PARITY,
		ST_STOP
	} serial_state_type;

	// bit 0 is the data ready flag; reads as line_status_reg[6:0]
	typedef struct packed {
		logic txIdle;
		logic txEmpty;
		logic breakSeen;
		logic frameErr;
		logic parityErr;
		logic overrun;
		logic ready;
	} line_flags_type;

	localparam line_flags_type LINE_FLAGS_RESET = 7'h60;

endpackage

// file: uart_remote_model.sv
/*
 * Remote serial transceiver on the far end of the line, 8N1 frames.
 * Assumes baud_divider 1, so one bit lasts 32 core_clk cycles.
 */
`timescale 1ns/1ps
module uart_remote_model #(
	parameter int BIT_CYC = 32
) (
	input  wire logic core_clk,
	input  wire logic lineIn,
	output logic      lineOut
);
	logic [7:0] rxWord;
	int         rxCount;

	initial begin
		lineOut = 1'b1;
		rxWord = 8'h00;
		rxCount = 0;
	end

	// ==========================================================
	// transmit: a low stop bit with zero data makes a break
	task automatic send_word(input logic [7:0] w, input logic stopBit);
		logic [9:0] f;
		f = {stopBit, w, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			lineOut <= f[i];
			repeat (BIT_CYC - 1) @(posedge core_clk);
		end
		@(posedge core_clk);
		lineOut <= 1'b1;
		repeat (BIT_CYC) @(posedge core_clk);
	endtask

	// ==========================================================
	// receive: sample in the middle of each bit
	initial forever begin
		@(negedge lineIn);
		repeat (BIT_CYC / 2) @(posedge core_clk);
		if (lineIn === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge core_clk);
				rxWord[i] = lineIn;
			end
			repeat (BIT_CYC) @(posedge core_clk);
			rxCount++;
		end
	end
endmodule // uart_remote_model
